// ### src/tac_pkg.sv
// How it works
// - pen bit reads one while touch present
// - pen mode zero host-run, one self-run scans
// - stop/status reads zero busy, one idle
// - writing stop aborts everything and powers down
// - conversion command byte also writes stop
// - resolution 10 or 12 bits, both paths
// - clock field divides oscillator 1/2/4/4
// - stabilization delay from eight-entry table
// - precharge delay from eight-entry table
// - sense wait after each coordinate conversion
// - wait detection drives pin high untouched
// - long sampling adds 500ns per conversion
// - sixteen-bit word field order, D15 to D0
// - reset reads 4000h, written content 0000h
// - command byte, address, direction, 16-bit word
package tac_pkg;

    // clock and time base
    localparam int CLK_PERIOD_NS = 10;
    localparam int US_NS = 1000;
    localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
    localparam int OSC_FREQ_KHZ = 4000;
    localparam int OSC_CYCLES = 1000000 / (OSC_FREQ_KHZ * CLK_PERIOD_NS);
    localparam int LONG_SAMPLE_NS = 500;
    localparam int LONG_SAMPLE_OSC = (LONG_SAMPLE_NS * OSC_FREQ_KHZ + 999999) / 1000000;
    localparam int NORM_SAMPLE_OSC = 3;

    // serial command layout
    localparam logic [3:0] CFG_ADDR = 4'hC;
    localparam logic [4:0] CMD_LAST_BIT = 5'h07;
    localparam logic [4:0] FRAME_LAST_BIT = 5'h17;
    localparam int CMD_ID_BIT = 7;
    localparam int CMD_ADDR_LSB = 3;
    localparam int CMD_RD_BIT = 0;
    localparam int B1_RES_BIT = 2;
    localparam int B1_STOP_BIT = 0;
    localparam logic [3:0] FUNC_XYZ = 4'h0;
    localparam logic [3:0] FUNC_XY = 4'h1;

    // reset values
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [15:0] READ_RESET = 16'h4000;

    // delay tables in microseconds, indexed by field code
    localparam logic [16:0] PV_US [8] = '{17'h00000, 17'h00064, 17'h001F4, 17'h003E8,
                                          17'h01388, 17'h02710, 17'h0C350, 17'h186A0};
    localparam logic [16:0] PR_US [8] = '{17'h00014, 17'h00054, 17'h00114, 17'h00154,
                                          17'h00414, 17'h00454, 17'h00514, 17'h00554};
    localparam logic [16:0] SN_US [8] = '{17'h00020, 17'h00060, 17'h00220, 17'h00260,
                                          17'h00820, 17'h00860, 17'h00A20, 17'h00A60};

    // field order D15..D0 matches the register word
    typedef struct packed {
        logic pen_status_mode;
        logic converter_stop_status;
        logic resolution_select;
        logic conv_clock_div_hi;
        logic conv_clock_div_lo;
        logic [2:0] panel_settle_time;
        logic [2:0] precharge_time_sel;
        logic [2:0] sense_time_sel;
        logic wait_touch_detect;
        logic long_sample_enable;
    } tac_cfg_t;

    typedef struct packed {
        logic precharge_en;
        logic drive_en;
        logic sample_en;
        logic convert_en;
        logic adc_power_on;
    } tac_ana_t;

    typedef enum logic [2:0] {
        SQ_IDLE, SQ_PRECHARGE, SQ_CHECK, SQ_SETTLE, SQ_SAMPLE, SQ_CONVERT, SQ_SENSE
    } tac_state_t;

    // converter clock period in mclk cycles
    function automatic logic [7:0] tac_adc_unit(input logic hi, input logic lo);
        logic [7:0] u;
        u = 8'(OSC_CYCLES);
        if (hi) u = 8'(4 * OSC_CYCLES);
        else if (lo) u = 8'(2 * OSC_CYCLES);
        return u;
    endfunction

endpackage

// ### src/tac_delay_timer.sv
`timescale 1ns/1ps
// counts units of unit_len mclk cycles; expired holds until the next load
module tac_delay_timer
    import tac_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic load,
    input wire logic [16:0] units,
    input wire logic [7:0] unit_len,
    output logic expired
);
    typedef struct packed {
        logic running;
        logic [16:0] left;
        logic [7:0] pre;
        logic [7:0] unit_q;
    } tac_tmr_st_t;

    tac_tmr_st_t s_q, s_d;

    ////////////////////////////////////////////////////////////////
    // prescaler restarts on load so a least time is never cut short
    always_comb begin
        s_d = s_q;
        if (load) begin
            s_d.running = 1'b1;
            s_d.left = units;
            s_d.unit_q = unit_len;
            s_d.pre = unit_len - 8'h01;
        end else if (s_q.running && s_q.left != 17'h00000) begin
            if (s_q.pre == 8'h00) begin
                s_d.pre = s_q.unit_q - 8'h01;
                s_d.left = s_q.left - 17'h00001;
            end else begin
                s_d.pre = s_q.pre - 8'h01;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) s_q <= '0;
        else s_q <= s_d;
    end

    assign expired = s_q.running && s_q.left == 17'h00000;

endmodule

// ### src/tac_cfg_core.sv
`timescale 1ns/1ps
module tac_cfg_core
    import tac_pkg::*;
#(
    parameter int unsigned US_CYCLES_P = US_CYCLES
)
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe_n,
    input wire logic pen_touch,
    output logic pen_irq_data_ready_pin_n,
    output tac_ana_t ana,
    output logic res_12bit,
    output logic [1:0] coord_sel
);
    typedef struct packed {
        logic sclk_q;
        logic [4:0] bit_cnt;
        logic [15:0] shin;
        logic [7:0] cmd;
        logic rd_phase;
        logic [15:0] tx;
        logic sdo;
        tac_cfg_t cfg;
        logic [3:0] func;
        tac_state_t st;
        logic [1:0] coord;
        logic pen_q;
        tac_ana_t ana;
        logic pin_n;
    } tac_core_st_t;

    tac_core_st_t s_q, s_d;
    logic rise, fall, start, t_load, t_expired;
    logic [7:0] cmd_w;
    logic [15:0] readback;
    logic [16:0] t_units;
    logic [7:0] t_unit;

    function automatic tac_ana_t ana_of(input tac_state_t st, input logic stop);
        tac_ana_t a;
        a.precharge_en = st == SQ_PRECHARGE;
        a.drive_en = st == SQ_SETTLE || st == SQ_SAMPLE || st == SQ_CONVERT;
        a.sample_en = st == SQ_SAMPLE;
        a.convert_en = st == SQ_CONVERT;
        a.adc_power_on = !stop && st != SQ_IDLE;
        return a;
    endfunction

    function automatic logic [1:0] last_coord(input logic [3:0] f);
        logic [1:0] n;
        n = 2'h0;
        if (f == FUNC_XYZ) n = 2'h3;
        else if (f == FUNC_XY) n = 2'h1;
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////
    // status bits are live, control bits as written
    assign readback = {s_q.pen_q, s_q.st == SQ_IDLE, 14'(s_q.cfg)};

    ////////////////////////////////////////////////////////////////
    // serial slave and scan sequencer share one next-state process
    always_comb begin
        s_d = s_q;
        t_load = 1'b0;
        t_units = 17'h00000;
        t_unit = 8'(US_CYCLES_P);
        start = 1'b0;
        cmd_w = {s_q.shin[6:0], sdi};
        rise = !cs_n && sclk && !s_q.sclk_q;
        fall = !cs_n && !sclk && s_q.sclk_q;
        s_d.sclk_q = sclk;
        s_d.pen_q = pen_touch;
        // deselect drops any partial command
        if (cs_n) begin
            s_d.bit_cnt = 5'h00;
            s_d.rd_phase = 1'b0;
        end else if (rise) begin
            s_d.shin = {s_q.shin[14:0], sdi};
            s_d.bit_cnt = s_q.bit_cnt + 5'h01;
            if (s_q.bit_cnt == CMD_LAST_BIT) begin
                s_d.cmd = cmd_w;
                if (cmd_w[CMD_ID_BIT]) begin
                    // conversion command byte: no data word follows
                    s_d.bit_cnt = 5'h00;
                    s_d.cfg.resolution_select = cmd_w[B1_RES_BIT];
                    s_d.cfg.converter_stop_status = cmd_w[B1_STOP_BIT];
                    s_d.func = cmd_w[6:3];
                    start = !cmd_w[B1_STOP_BIT] && !s_q.cfg.pen_status_mode;
                end else if (cmd_w[CMD_RD_BIT]) begin
                    // other addresses live outside this block and read as zero
                    s_d.tx = (cmd_w[6:3] == CFG_ADDR) ? readback : 16'h0000;
                    s_d.rd_phase = 1'b1;
                end
            end else if (s_q.bit_cnt == FRAME_LAST_BIT) begin
                s_d.bit_cnt = 5'h00;
                s_d.rd_phase = 1'b0;
                if (!s_q.cmd[CMD_RD_BIT] && s_q.cmd[6:3] == CFG_ADDR) begin
                    s_d.cfg = tac_cfg_t'({s_q.shin[14:0], sdi});
                end
            end
        end else if (fall && s_q.rd_phase) begin
            s_d.sdo = s_q.tx[15];
            s_d.tx = {s_q.tx[14:0], 1'b0};
        end

        // stop wins over every sequencer step, pen still down or not
        if (s_d.cfg.converter_stop_status) begin
            s_d.st = SQ_IDLE;
        end else begin
            unique case (s_q.st)
                SQ_IDLE: begin
                    // self-run only for the scan codes, host start otherwise
                    if (start || (s_d.cfg.pen_status_mode && s_q.pen_q
                        && (s_q.func == FUNC_XYZ || s_q.func == FUNC_XY))) begin
                        s_d.st = SQ_PRECHARGE;
                        s_d.coord = 2'h0;
                        t_load = 1'b1;
                        t_units = PR_US[s_d.cfg.precharge_time_sel];
                    end
                end
                SQ_PRECHARGE: begin
                    if (t_expired) s_d.st = SQ_CHECK;
                end
                SQ_CHECK: begin
                    if (s_d.cfg.pen_status_mode && !s_q.pen_q) begin
                        s_d.st = SQ_IDLE;
                    end else begin
                        s_d.st = SQ_SETTLE;
                        t_load = 1'b1;
                        t_units = PV_US[s_d.cfg.panel_settle_time];
                    end
                end
                SQ_SETTLE: begin
                    if (t_expired) begin
                        s_d.st = SQ_SAMPLE;
                        t_load = 1'b1;
                        t_unit = 8'(OSC_CYCLES);
                        t_units = s_d.cfg.long_sample_enable ? 17'(NORM_SAMPLE_OSC + LONG_SAMPLE_OSC)
                                                             : 17'(NORM_SAMPLE_OSC);
                    end
                end
                SQ_SAMPLE: begin
                    if (t_expired) begin
                        s_d.st = SQ_CONVERT;
                        t_load = 1'b1;
                        t_unit = tac_adc_unit(s_d.cfg.conv_clock_div_hi, s_d.cfg.conv_clock_div_lo);
                        t_units = s_d.cfg.resolution_select ? 17'h0000C : 17'h0000A;
                    end
                end
                SQ_CONVERT: begin
                    if (t_expired) begin
                        s_d.st = SQ_SENSE;
                        t_load = 1'b1;
                        t_units = SN_US[s_d.cfg.sense_time_sel];
                    end
                end
                SQ_SENSE: begin
                    // next coordinate, or a fresh pass while self-run; touch is checked after precharge
                    if (t_expired) begin
                        t_load = 1'b1;
                        if (s_q.coord != last_coord(s_q.func)) begin
                            s_d.coord = s_q.coord + 2'h1;
                            s_d.st = SQ_SETTLE;
                            t_units = PV_US[s_d.cfg.panel_settle_time];
                        end else if (s_d.cfg.pen_status_mode) begin
                            s_d.coord = 2'h0;
                            s_d.st = SQ_PRECHARGE;
                            t_units = PR_US[s_d.cfg.precharge_time_sel];
                        end else begin
                            s_d.st = SQ_IDLE;
                        end
                    end
                end
                default: begin
                    s_d.st = SQ_IDLE; // unused state code falls back to idle
                end
            endcase
        end
        s_d.ana = ana_of(s_d.st, s_d.cfg.converter_stop_status);
        // pin low marks touch; high while untouched and watching
        s_d.pin_n = !((s_d.cfg.pen_status_mode || s_d.cfg.wait_touch_detect) && pen_touch);
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            s_q <= '0;
            s_q.st <= SQ_IDLE;
            s_q.pin_n <= 1'b1;
            s_q.cfg <= tac_cfg_t'(CFG_RESET);
        end else begin
            s_q <= s_d;
        end
    end

    tac_delay_timer u_timer (
        .mclk(mclk),
        .reset_n(reset_n),
        .load(t_load),
        .units(t_units),
        .unit_len(t_unit),
        .expired(t_expired)
    );

    assign sdo = s_q.sdo;
    assign sdo_oe_n = cs_n; // releases the shared data line when deselected
    assign pen_irq_data_ready_pin_n = s_q.pin_n;
    assign ana = s_q.ana;
    assign res_12bit = s_q.cfg.resolution_select;
    assign coord_sel = s_q.coord;

    ////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    a_read_status_bits: assert property (
        ($rose(s_q.rd_phase) && s_q.cmd[6:3] == CFG_ADDR)
        |-> s_q.tx[15] == $past(s_q.pen_q) && s_q.tx[14] == ($past(s_q.st) == SQ_IDLE))
        else $error("status bits in read word wrong");
    a_stop_aborts: assert property (
        $rose(s_q.cfg.converter_stop_status) |-> s_q.st == SQ_IDLE && !s_q.ana.adc_power_on)
        else $error("stop did not abort converter");
    a_host_mode_holds: assert property (
        (s_q.st == SQ_IDLE && !s_q.cfg.pen_status_mode && !rise) |=> s_q.st == SQ_IDLE)
        else $error("host mode started on its own");
    a_pen_mode_start: assert property (
        (s_q.st == SQ_IDLE && s_q.cfg.pen_status_mode && !s_q.cfg.converter_stop_status
         && s_q.pen_q && (s_q.func == FUNC_XYZ || s_q.func == FUNC_XY) && !rise) |=> s_q.st == SQ_PRECHARGE)
        else $error("pen touch did not start scan");
    a_byte1_write: assert property (
        (rise && s_q.bit_cnt == CMD_LAST_BIT && s_q.shin[6])
        |=> s_q.cfg.converter_stop_status == $past(sdi) && s_q.cfg.resolution_select == $past(s_q.shin[1]))
        else $error("conversion byte did not update stop or resolution");
    a_cfg_word_write: assert property (
        (rise && s_q.bit_cnt == FRAME_LAST_BIT && !s_q.cmd[CMD_RD_BIT] && s_q.cmd[6:3] == CFG_ADDR)
        |=> 16'(s_q.cfg) == $past({s_q.shin[14:0], sdi}))
        else $error("config word write lost");
    a_settle_zero: assert property (
        ($rose(s_q.st == SQ_SETTLE) && s_q.cfg.panel_settle_time == 3'h0 && !s_q.cfg.converter_stop_status)
        |=> s_q.st == SQ_SAMPLE || s_q.cfg.converter_stop_status)
        else $error("zero stabilization took time");
    a_pin_untouched: assert property (
        !pen_touch |=> pen_irq_data_ready_pin_n)
        else $error("pin low without touch");
    a_reset_readback: assert property (
        $rose(reset_n) |-> s_q.cfg == tac_cfg_t'(CFG_RESET) && s_q.st == SQ_IDLE)
        else $error("reset value wrong");

    c_pen_scan: cover property (s_q.cfg.pen_status_mode && $rose(s_q.st == SQ_PRECHARGE));
    c_host_convert: cover property (!s_q.cfg.pen_status_mode && $rose(s_q.st == SQ_CONVERT));
    c_stop_mid_scan: cover property (s_q.st == SQ_CONVERT ##1 s_q.cfg.converter_stop_status);
    c_read_frame: cover property ($fell(s_q.rd_phase) && !cs_n);

endmodule

// ### verif/tac_host_model.sv
`timescale 1ns/1ps
// host end of the serial link: mode 0, msb first, sclk well below mclk
module tac_host_model (
    input wire logic mclk,
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo
);
    // link idles deselected with sclk parked low
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one frame: command byte, then the word for register access; n is 8 or 24
    // four mclk per sclk half period keeps the device's edge detector happy
    task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, input int n, output logic [15:0] rd);
        logic [23:0] sh;
        sh = {cmd, wd};
        rd = 16'h0000;
        @(negedge mclk);
        cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            @(negedge mclk);
            sclk = 1'b0;
            sdi = sh[23 - i]; // msb first
            repeat (4) @(negedge mclk);
            sclk = 1'b1;
            rd = {rd[14:0], sdo}; // last sixteen rises carry the read word
            repeat (3) @(negedge mclk);
        end
        @(negedge mclk);
        sclk = 1'b0;
        repeat (2) @(negedge mclk);
        cs_n = 1'b1;
        sdi = ~sdi; // released line must not look like the last bit
        repeat (4) @(negedge mclk);
    endtask
endmodule

// ### verif/test_touch_adc_config_register.sv
`timescale 1ns/1ps
module test_touch_adc_config_register
    import tac_pkg::*;
();
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic pen_touch = 1'b0;
    logic sclk, cs_n, sdi, sdo, sdo_oe_n, pin_n, res_12bit;
    logic [1:0] coord_sel;
    tac_ana_t ana;
    int fails = 0;
    int n_checks = 0;
    // scan cases: word, precharge, sample and convert lengths in mclk (one mclk per microsecond)
    logic [15:0] cw [4] = '{16'h0000, 16'h2821, 16'h3060, 16'h18E0};
    int pre [4] = '{20, 84, 340, 1364};
    int smp [4] = '{75, 125, 75, 75};
    int cnv [4] = '{250, 600, 1200, 1000};

    // 100 MHz
    always #5 mclk = ~mclk;

    // released data line floats to its pull-up, so a missing enable shows up as all ones
    tac_host_model host_u (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo_oe_n ? 1'b1 : sdo));

    tac_cfg_core #(.US_CYCLES_P(1)) dut_u (
        .mclk(mclk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
        .sdo_oe_n(sdo_oe_n), .pen_touch(pen_touch), .pen_irq_data_ready_pin_n(pin_n),
        .ana(ana), .res_12bit(res_12bit), .coord_sel(coord_sel)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // comparison, verdict and access helpers
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        if (fails == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // phase lengths carry up to two cycles of entry slack
    task automatic near(input string what, input int n, input int e);
        check(what, 16'((n >= e && n <= e + 2) ? e : n), 16'(e));
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        logic [15:0] x;
        host_u.xfer({1'b0, a, 3'b000}, d, 24, x);
    endtask

    task automatic rchk(input logic [3:0] a, input logic [15:0] e, input string what);
        logic [15:0] d;
        host_u.xfer({1'b0, a, 3'b001}, 16'h0000, 24, d);
        check(what, d, e);
    endtask

    task automatic conv(input logic [7:0] c);
        logic [15:0] x;
        host_u.xfer(c, 16'h0000, 8, x);
    endtask

    // length of the next high pulse on one analog control, bounded both ways
    task automatic plen(input int b, output int n);
        int w;
        n = 0;
        w = 0;
        // sampled on the falling edge, away from the edge that updates ana
        while (ana[b] !== 1'b1 && w < 5000) begin
            @(negedge mclk);
            w++;
        end
        while (ana[b] === 1'b1 && n < 5000) begin
            @(negedge mclk);
            n++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        int n0, n1, n2;
        logic [7:0] c;
        repeat (16) @(negedge mclk);
        reset_n = 1'b1;
        @(negedge mclk);
        check("pin", pin_n, 1'b1);
        check("ana", ana, 5'h00);
        check("res", res_12bit, 1'b0);
        check("oe idle", sdo_oe_n, 1'b1);
        rchk(4'hC, 16'h4000, "reset word");
        wr(4'hC, 16'h2A55);
        rchk(4'hC, 16'h6A55, "word");
        check("res", res_12bit, 1'b1);
        wr(4'hD, 16'hFFFF);
        rchk(4'hD, 16'h0000, "other addr");
        rchk(4'hC, 16'h6A55, "kept word");
        pen_touch = 1'b1;
        rchk(4'hC, 16'hEA55, "pen word");
        check("pin unwatched", pin_n, 1'b1);
        wr(4'hC, 16'h0002);
        repeat (4) @(negedge mclk);
        check("pin touch", pin_n, 1'b0);
        pen_touch = 1'b0;
        repeat (4) @(negedge mclk);
        check("pin idle", pin_n, 1'b1);
        // pen mode off, so each scan here is started by the conversion byte
        for (int i = 0; i < 4; i++) begin
            wr(4'hC, cw[i]);
            rchk(4'hC, cw[i] | 16'h4000, "cfg word");
            c = {1'b1, 4'h1, cw[i][13], 2'b00}; // xy scan; undivided clock only at 10 bits
            fork
                conv(c);
                begin
                    plen(4, n0);
                    plen(2, n1);
                    plen(1, n2);
                end
            join
            near("precharge", n0, pre[i]);
            near("sample", n1, smp[i]);
            near("convert", n2, cnv[i]);
            check("res pin", res_12bit, cw[i][13]);
            rchk(4'hC, cw[i], "busy word");
            check("xy coord", coord_sel, 2'h1);
            if (i[0]) begin
                wr(4'hC, cw[i] | 16'h4000);
            end else begin
                conv(c | 8'h01);
            end
            repeat (2) @(negedge mclk);
            check("stopped", ana, 5'h00);
            rchk(4'hC, cw[i] | 16'h4000, "idle word");
        end
        // device-started scan on touch; xyz code sent first, its host start refused in pen mode
        wr(4'hC, 16'h8000);
        conv(8'h80);
        check("no host start", ana, 5'h00);
        pen_touch = 1'b1;
        plen(2, n1);
        near("pen scan", n1, 75);
        rchk(4'hC, 16'h8000, "pen busy");
        check("pin pen", pin_n, 1'b0);
        // xyz scan must reach its fourth coordinate
        for (int k = 0; k < 5000 && coord_sel !== 2'h3; k++) begin
            @(negedge mclk);
        end
        check("xyz coord", coord_sel, 2'h3);
        wr(4'hC, 16'h4000);
        pen_touch = 1'b0;
        repeat (2) @(negedge mclk);
        check("pen stop", ana, 5'h00);
        rchk(4'hC, 16'h4000, "end word");
        final_report();
    end

    // cuts a hang short well beyond the expected run of some 13k cycles
    initial begin
        #600000;
        fails++;
        final_report();
    end
endmodule
